// file: core/adc_cfg_bank.sv
// configuration register bank with clock dividers and output float timing
`include "adc_cfg_regs.svh"
`default_nettype none

module adc_cfg_bank #(
   parameter int CHANNELS = 4
) (
   input  wire logic        CLK_I,
   input  wire logic        ARST_N_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        CRYSTAL_CLOCK_INPUT_PIN_I,
   input  wire logic        SERIAL_CLOCK_PIN_I,
   input  wire logic        SYNC_MASTER_MODE_I,
   input  wire logic [3:0]  CHANNEL_ENABLE_I,
   input  wire logic        FRAME_LAST_BIT_I,
   input  wire logic        FRAME_START_I,
   input  wire logic        CMD_VALID_I,
   input  wire logic        CMD_CRC_OK_I,
   output logic             CMD_ACCEPT_O,
   output logic             WATCHDOG_ENABLE_O,
   output logic             CRC_ENABLE_O,
   output logic             CRC_ALL_BITS_O,
   output logic [3:0]       FRAME_WORDS_O,
   output logic             DATA_OUT_ENABLE_N_O,
   output logic             INTERNAL_CLOCK_TICK_O,
   output logic             MODULATOR_CLOCK_TICK_O,
   output logic             DATA_RATE_TICK_O,
   output logic             SERIAL_CLOCK_O,
   output logic             SERIAL_CLOCK_OE_N_O
);

   // ***********************************************
   // timing constants
   // ***********************************************
   localparam int FLOAT_CYC0 = (`FLOAT_NS_0 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int FLOAT_CYC1 = (`FLOAT_NS_1 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int FLOAT_CYC2 = (`FLOAT_NS_2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int FLOAT_CYC3 = (`FLOAT_NS_3 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      logic [7:0]               dsc;
      logic [7:0]               ck1;
      logic [7:0]               ck2;
      logic [31:0]              rdata;
      logic [2:0]               sclk_pipe;
      logic [2:0]               xtal_pipe;
      logic                     sclk_lvl;
      logic                     xtal_lvl;
      logic [3:0]               words;
      logic [3:0]               icnt;
      logic [3:0]               mcnt;
      logic [11:0]              ocnt;
      logic                     ick_tick;
      logic                     mod_tick;
      logic                     rate_tick;
      logic                     sclk_out;
      logic [2:0]               fcnt;
      adc_cfg_pkg::link_state_t link;
      logic                     oe_n;
      logic                     accept;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // ***********************************************
   // helpers
   // ***********************************************
   // divider code to half-period count minus one; reserved 000 behaves as 001
   function automatic logic [3:0] half_limit(input logic [2:0] code);
      return (code == 3'h0) ? 4'h0 : 4'({1'b0, code} - 4'h1);
   endfunction

   // divider code to full-period count minus one; reserved 000 behaves as 001
   function automatic logic [3:0] div_limit(input logic [2:0] code);
      logic [3:0] c;
      c = (code == 3'h0) ? 4'h1 : {1'b0, code};
      return 4'((c << 1) - 4'h1);
   endfunction

   // oversampling code to ratio minus one
   function automatic logic [11:0] osr_limit(input logic [3:0] code);
      logic [11:0] r;
      case (code)
         4'h0:    r = 12'hFFF;
         4'h1:    r = 12'h7FF;
         4'h2:    r = 12'h3FF;
         4'h3:    r = 12'h31F;
         4'h4:    r = 12'h2FF;
         4'h5:    r = 12'h1FF;
         4'h6:    r = 12'h18F;
         4'h7:    r = 12'h17F;
         4'h8:    r = 12'h0FF;
         4'h9:    r = 12'h0C7;
         4'hA:    r = 12'h0BF;
         4'hB:    r = 12'h07F;
         4'hC:    r = 12'h05F;
         4'hD:    r = 12'h03F;
         4'hE:    r = 12'h02F;
         default: r = 12'h01F;
      endcase
      return r;
   endfunction

   // float delay code to clock cycles
   function automatic logic [2:0] float_cycles(input logic [1:0] code);
      logic [2:0] n;
      case (code)
         2'h0:    n = 3'(FLOAT_CYC0);
         2'h1:    n = 3'(FLOAT_CYC1);
         2'h2:    n = 3'(FLOAT_CYC2);
         default: n = 3'(FLOAT_CYC3);
      endcase
      return n;
   endfunction

   logic       src_edge;
   logic [3:0] words_var;
   logic       bus_access;
   logic       hit_dsc;
   logic       hit_ck1;
   logic       hit_ck2;

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      state_next = state_reg;
      state_next.ick_tick = 1'b0;
      state_next.mod_tick = 1'b0;
      state_next.rate_tick = 1'b0;
      state_next.accept = 1'b0;
      state_next.sclk_pipe = {state_reg.sclk_pipe[1:0], SERIAL_CLOCK_PIN_I};
      state_next.xtal_pipe = {state_reg.xtal_pipe[1:0], CRYSTAL_CLOCK_INPUT_PIN_I};
      words_var = 4'h0;
      src_edge = 1'b0;

      // address decode
      bus_access = PSEL_I && PENABLE_I;
      hit_dsc = 1'b0;
      hit_ck1 = 1'b0;
      hit_ck2 = 1'b0;
      if (PADDR_I == `DSC_ADDR) begin
         hit_dsc = 1'b1;
      end else if (PADDR_I == `CK1_ADDR) begin
         hit_ck1 = 1'b1;
      end else if (PADDR_I == `CK2_ADDR) begin
         hit_ck2 = 1'b1;
      end

      // register writes
      if (bus_access && PWRITE_I) begin
         if (hit_dsc) begin
            state_next.dsc = PWDATA_I[7:0];
         end
         if (hit_ck1) begin
            state_next.ck1 = PWDATA_I[7:0];
         end
         if (hit_ck2) begin
            state_next.ck2 = PWDATA_I[7:0];
         end
      end

      // read data captured in setup phase
      if (PSEL_I && !PENABLE_I) begin
         state_next.rdata = 32'h0000_0000;
         if (hit_dsc) begin
            state_next.rdata = {24'h00_0000, state_reg.dsc};
         end else if (hit_ck1) begin
            state_next.rdata = {24'h00_0000, state_reg.ck1};
         end else if (hit_ck2) begin
            state_next.rdata = {24'h00_0000, state_reg.ck2};
         end
      end

      // pin levels change only once second and third stage agree
      if (state_reg.sclk_pipe[2] == state_reg.sclk_pipe[1]) begin
         state_next.sclk_lvl = state_reg.sclk_pipe[2];
      end
      if (state_reg.xtal_pipe[2] == state_reg.xtal_pipe[1]) begin
         state_next.xtal_lvl = state_reg.xtal_pipe[2];
      end

      // rising edge of the selected input clock, from the filtered level
      if (state_reg.ck1[`CK1_SRC_BIT]) begin
         src_edge = state_reg.sclk_pipe[2] && state_reg.sclk_pipe[1]
                  && !state_reg.sclk_lvl;
      end else begin
         src_edge = state_reg.xtal_pipe[2] && state_reg.xtal_pipe[1]
                  && !state_reg.xtal_lvl;
      end

      // input clock divider forms internal clock, toggling every half period
      if (src_edge) begin
         if (state_reg.icnt >= half_limit(state_reg.ck1[`CK1_DIV_HI:`CK1_DIV_LO])) begin
            state_next.icnt = 4'h0;
            state_next.sclk_out = !state_reg.sclk_out;
            state_next.ick_tick = !state_reg.sclk_out;
         end else begin
            state_next.icnt = 4'(state_reg.icnt + 4'h1);
         end
      end

      // modulator divider on internal clock ticks
      if (state_reg.ick_tick) begin
         if (state_reg.mcnt >= div_limit(state_reg.ck2[`CK2_MDIV_HI:`CK2_MDIV_LO])) begin
            state_next.mcnt = 4'h0;
            state_next.mod_tick = 1'b1;
         end else begin
            state_next.mcnt = 4'(state_reg.mcnt + 4'h1);
         end
      end

      // oversampling counter gives the data rate
      if (state_reg.mod_tick) begin
         if (state_reg.ocnt >= osr_limit(state_reg.ck2[`CK2_OSR_HI:`CK2_OSR_LO])) begin
            state_next.ocnt = 12'h000;
            state_next.rate_tick = 1'b1;
         end else begin
            state_next.ocnt = 12'(state_reg.ocnt + 12'h001);
         end
      end

      // data output float sequencing
      case (state_reg.link)
         adc_cfg_pkg::LINK_IDLE: begin
            state_next.oe_n = 1'b1;
            if (FRAME_START_I) begin
               state_next.link = adc_cfg_pkg::LINK_SHIFT;
               state_next.oe_n = 1'b0;
            end
         end
         adc_cfg_pkg::LINK_SHIFT: begin
            if (FRAME_LAST_BIT_I) begin
               state_next.fcnt = float_cycles(state_reg.dsc[`DSC_FLOAT_HI:`DSC_FLOAT_LO]);
               state_next.link = adc_cfg_pkg::LINK_HOLD;
            end
         end
         adc_cfg_pkg::LINK_HOLD: begin
            if (state_reg.fcnt <= 3'h1) begin
               state_next.oe_n = 1'b1;
               state_next.link = adc_cfg_pkg::LINK_IDLE;
            end else begin
               state_next.fcnt = 3'(state_reg.fcnt - 3'h1);
            end
         end
         default: begin
            state_next.link = adc_cfg_pkg::LINK_IDLE;
         end
      endcase

      // command acceptance gated by crc check
      if (CMD_VALID_I) begin
         state_next.accept = !state_reg.dsc[`DSC_CRCEN_BIT] || CMD_CRC_OK_I;
      end

      // variable frame: status word, enabled channels, optional crc
      for (int i = 0; i < CHANNELS; i++) begin
         words_var = 4'(words_var + {3'h0, CHANNEL_ENABLE_I[i]});
      end
      words_var = 4'(words_var + `STATUS_WORDS + {3'h0, state_reg.dsc[`DSC_CRCEN_BIT]});
      state_next.words = state_reg.dsc[`DSC_FIXED_BIT]
                       ? ((CHANNELS > 2) ? `FIXED_WORDS_FOUR : `FIXED_WORDS_TWO)
                       : words_var;
   end

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_reg <= '0;
         state_reg.dsc <= `DSC_RESET;
         state_reg.ck1 <= `CK1_RESET;
         state_reg.ck2 <= `CK2_RESET;
         state_reg.oe_n <= 1'b1;
         state_reg.link <= adc_cfg_pkg::LINK_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   // apb answers in the access cycle, never errors
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = 1'b0;
   assign PRDATA_O = state_reg.rdata;

   // configuration fields to the frame logic
   assign WATCHDOG_ENABLE_O = state_reg.dsc[`DSC_WDOG_BIT];
   assign CRC_ALL_BITS_O = state_reg.dsc[`DSC_CRCMODE_BIT];
   assign CRC_ENABLE_O = state_reg.dsc[`DSC_CRCEN_BIT];
   assign FRAME_WORDS_O = state_reg.words;
   assign CMD_ACCEPT_O = state_reg.accept;
   assign DATA_OUT_ENABLE_N_O = state_reg.oe_n;

   // clock ticks and serial clock drive
   assign INTERNAL_CLOCK_TICK_O = state_reg.ick_tick;
   assign MODULATOR_CLOCK_TICK_O = state_reg.mod_tick;
   assign DATA_RATE_TICK_O = state_reg.rate_tick;
   assign SERIAL_CLOCK_O = state_reg.sclk_out;
   assign SERIAL_CLOCK_OE_N_O = !SYNC_MASTER_MODE_I;

endmodule
`default_nettype wire

// file: shared/adc_cfg_regs.svh
// register offsets, field positions, reset values and timing figures of the config bank
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH

// printed offsets are register indices; byte address is four times the index
`define DSC_INDEX         8'h0C
`define CK1_INDEX         8'h0D
`define CK2_INDEX         8'h0E
`define DSC_ADDR          12'h030
`define CK1_ADDR          12'h034
`define CK2_ADDR          12'h038

`define DSC_RESET         8'h3C
`define CK1_RESET         8'h08
`define CK2_RESET         8'h86

`define DSC_WDOG_BIT      7
`define DSC_CRCMODE_BIT   6
`define DSC_DLY2_HI       5
`define DSC_DLY2_LO       4
`define DSC_FLOAT_HI      3
`define DSC_FLOAT_LO      2
`define DSC_FIXED_BIT     1
`define DSC_CRCEN_BIT     0

`define CK1_SRC_BIT       7
`define CK1_DIV_HI        3
`define CK1_DIV_LO        1
`define CK2_MDIV_HI       7
`define CK2_MDIV_LO       5
`define CK2_OSR_HI        3
`define CK2_OSR_LO        0

// float delay minimum times in ns, per code
`define FLOAT_NS_0        6
`define FLOAT_NS_1        8
`define FLOAT_NS_2        10
`define FLOAT_NS_3        12
`define CLK_PERIOD_NS     5

// frame word counts
`define FIXED_WORDS_FOUR  4'h6
`define FIXED_WORDS_TWO   4'h4
`define STATUS_WORDS      4'h1

`endif

// file: shared/adc_cfg_pkg.sv
// types shared by the config bank
`default_nettype none
package adc_cfg_pkg;
   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_SHIFT,
      LINK_HOLD
   } link_state_t;
endpackage
`default_nettype wire

// file: verification/adc_clk_source.sv
// clock source model standing at the clock pins of the bank
`default_nettype none
module adc_clk_source (
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic frame_i,
   output var  logic xtal_o,
   output var  logic sclk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic half;
   initial half = 1'b0;
   initial xtal_o = 1'b0;
   initial sclk_o = 1'b0;
   // pins toggle every second cycle so each level lasts two samples
   // and passes the bank's agreeing filter; serial clock idles low outside frames
   always @(posedge clk_i) begin
      half <= !half;
      xtal_o <= run_i ? xtal_o ^ half : 1'b0;
      sclk_o <= frame_i ? sclk_o ^ half : 1'b0;
   end
endmodule
`default_nettype wire

// file: verification/adc_cfg_bank_chk.sv
// assertion checker on the config bank ports
`include "adc_cfg_regs.svh"
`default_nettype none
module adc_cfg_bank_chk (
   input wire logic        CLK_I,
   input wire logic        ARST_N_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic        CMD_VALID_I,
   input wire logic        CMD_ACCEPT_O,
   input wire logic        WATCHDOG_ENABLE_O,
   input wire logic        CRC_ENABLE_O,
   input wire logic        CRC_ALL_BITS_O,
   input wire logic        FRAME_START_I,
   input wire logic        FRAME_LAST_BIT_I,
   input wire logic        DATA_OUT_ENABLE_N_O,
   input wire logic        SYNC_MASTER_MODE_I,
   input wire logic        SERIAL_CLOCK_OE_N_O
);
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (!ARST_N_I);
   logic dsc_wr;
   // completed write to the digital config word
   assign dsc_wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `DSC_ADDR;
   AST_WDOG_EN:
      assert property (dsc_wr |=> WATCHDOG_ENABLE_O == $past(PWDATA_I[7]))
      else $error("watchdog enable not taken from write");
   AST_CRC_MODE:
      assert property (dsc_wr |=> CRC_ALL_BITS_O == $past(PWDATA_I[6]))
      else $error("crc mode not taken from write");
   AST_CRC_EN:
      assert property (dsc_wr |=> CRC_ENABLE_O == $past(PWDATA_I[0]))
      else $error("crc enable not taken from write");
   AST_CFG_HOLD:
      assert property (!dsc_wr |=> $stable({WATCHDOG_ENABLE_O, CRC_ALL_BITS_O, CRC_ENABLE_O}))
      else $error("config outputs moved without a write");
   AST_CMD_IDLE:
      assert property (!CMD_VALID_I |=> !CMD_ACCEPT_O)
      else $error("command accepted without a command");
   AST_FLOAT_ON:
      assert property (FRAME_START_I |=> !DATA_OUT_ENABLE_N_O)
      else $error("data output not driven after frame start");
   AST_FLOAT_HOLD:
      assert property (FRAME_LAST_BIT_I && !DATA_OUT_ENABLE_N_O |=> !DATA_OUT_ENABLE_N_O [*2])
      else $error("data output floated too early");
   AST_SCLK_OE:
      assert property (SERIAL_CLOCK_OE_N_O == !SYNC_MASTER_MODE_I)
      else $error("serial clock enable wrong for mode");
endmodule
`default_nettype wire

// file: verification/test_adc_cfg_bank.sv
// self-checking bench for the config bank
`include "adc_cfg_regs.svh"
`default_nettype none
module test_adc_cfg_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, arst_n, psel, penable, pwrite, xrun, frm, smm;
   logic        fstart, flast, cvalid, crcok, pready, pslverr, cacc, wdog;
   logic        crcen, crcall, doen_n, itick, mtick, dtick, sclk, sclk_oe_n, xtal, spin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  chen, words;
   int          error_cnt, total_checks, cyc, n;
   adc_cfg_bank #(.CHANNELS(4)) u_adc_cfg_bank (.CLK_I(clk), .ARST_N_I(arst_n),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .CRYSTAL_CLOCK_INPUT_PIN_I(xtal), .SERIAL_CLOCK_PIN_I(spin),
      .SYNC_MASTER_MODE_I(smm), .CHANNEL_ENABLE_I(chen), .FRAME_LAST_BIT_I(flast),
      .FRAME_START_I(fstart), .CMD_VALID_I(cvalid), .CMD_CRC_OK_I(crcok),
      .CMD_ACCEPT_O(cacc), .WATCHDOG_ENABLE_O(wdog), .CRC_ENABLE_O(crcen),
      .CRC_ALL_BITS_O(crcall), .FRAME_WORDS_O(words), .DATA_OUT_ENABLE_N_O(doen_n),
      .INTERNAL_CLOCK_TICK_O(itick), .MODULATOR_CLOCK_TICK_O(mtick),
      .DATA_RATE_TICK_O(dtick), .SERIAL_CLOCK_O(sclk), .SERIAL_CLOCK_OE_N_O(sclk_oe_n));
   adc_clk_source u_adc_clk_source (.clk_i(clk), .run_i(xrun), .frame_i(frm),
      .xtal_o(xtal), .sclk_o(spin));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = !clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      apb(1'b1, a, {24'h0, d}, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
   endtask
   task automatic cmd(input logic ok, input logic e);
      @(posedge clk) cvalid <= 1'b1;
      crcok <= ok;
      @(posedge clk) cvalid <= 1'b0;
      @(negedge clk);
      chk(cacc, e);
   endtask
   function automatic logic tk(input int s);
      return s == 0 ? itick : s == 1 ? mtick : dtick;
   endfunction
   // wait for two ticks, then measure the spacing from the second one to the next tick
   task automatic gap(input int s, input int e);
      int k;
      k = 0;
      repeat (2) do begin @(negedge clk); k++; end while (tk(s) !== 1'b1 && k < 9000);
      k = 0;
      do begin @(negedge clk); k++; end while (tk(s) !== 1'b1 && k < 9000);
      chk(k, e);
   endtask
   initial begin
      {arst_n, psel, penable, pwrite, xrun, frm, smm, fstart, flast, cvalid, crcok} = '0;
      {cyc, error_cnt, total_checks} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      chen = 4'h3;
      do_reset();
      rd(`DSC_ADDR, 32'h3C);
      rd(`CK1_ADDR, 32'h08);
      rd(`CK2_ADDR, 32'h86);
      wr(12'h03C, 8'hFF);
      rd(12'h03C, 32'h0);
      wr(`DSC_ADDR, 8'hC3);
      rd(`DSC_ADDR, 32'hC3);
      chk({wdog, crcall, crcen}, 3'h7);
      cmd(1'b0, 1'b0);
      cmd(1'b1, 1'b1);
      chk(words, 6);
      wr(`DSC_ADDR, 8'h01);
      repeat (2) @(negedge clk);
      chk(words, 4);
      chen <= 4'hF;
      wr(`DSC_ADDR, 8'h30);
      rd(`DSC_ADDR, 32'h30);
      chk({wdog, crcall, crcen, words}, 7'h05);
      cmd(1'b0, 1'b1);
      do_reset();
      rd(`DSC_ADDR, 32'h3C);
      for (int c = 0; c < 4; c++) begin
         wr(`DSC_ADDR, 8'(c << 2));
         @(posedge clk) fstart <= 1'b1;
         @(posedge clk) fstart <= 1'b0;
         @(posedge clk) flast <= 1'b1;
         @(posedge clk) flast <= 1'b0;
         n = 0;
         @(negedge clk);
         while (doen_n === 1'b0 && n < 50) begin n++; @(negedge clk); end
         chk(n, (`FLOAT_NS_0 + 2 * c + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
      end
      chk(sclk_oe_n, 1'b1);
      smm <= 1'b1;
      xrun <= 1'b1;
      @(negedge clk);
      chk(sclk_oe_n, 1'b0);
      for (int d = 1; d < 8; d++) begin
         wr(`CK1_ADDR, 8'(d << 1));
         rd(`CK1_ADDR, 32'(d << 1));
         gap(0, 8 * d);
      end
      wr(`CK1_ADDR, 8'h02);
      for (int m = 1; m < 8; m++) begin
         wr(`CK2_ADDR, 8'((m << 5) | 15));
         gap(1, 16 * m);
      end
      wr(`CK2_ADDR, 8'h2F);
      rd(`CK2_ADDR, 32'h2F);
      gap(2, 512);
      wr(`CK2_ADDR, 8'h2C);
      gap(2, 1536);
      xrun <= 1'b0;
      wr(`CK1_ADDR, 8'h82);
      repeat (4) @(negedge clk);
      n = 0;
      repeat (100) @(negedge clk) if (itick !== 1'b0) n++;
      chk(n, 0);
      frm <= 1'b1;
      gap(0, 8);
      report_and_stop();
   end
endmodule
bind adc_cfg_bank adc_cfg_bank_chk u_adc_cfg_bank_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .CMD_VALID_I(CMD_VALID_I), .CMD_ACCEPT_O(CMD_ACCEPT_O),
   .WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O), .CRC_ENABLE_O(CRC_ENABLE_O),
   .CRC_ALL_BITS_O(CRC_ALL_BITS_O), .FRAME_START_I(FRAME_START_I),
   .FRAME_LAST_BIT_I(FRAME_LAST_BIT_I), .DATA_OUT_ENABLE_N_O(DATA_OUT_ENABLE_N_O),
   .SYNC_MASTER_MODE_I(SYNC_MASTER_MODE_I), .SERIAL_CLOCK_OE_N_O(SERIAL_CLOCK_OE_N_O));
`default_nettype wire
